// ===== sar_adc_ctrl_regs.vh
// Register map, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_CTRL_REGS_VH
`define SAR_ADC_CTRL_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CONTROL_STATUS 8'h00
`define OFS_INPUT_SELECT 8'h04
`define OFS_SPECIAL_FUNC 8'h08
`define OFS_RESULT_LOW 8'h0c
`define OFS_RESULT_HIGH 8'h10

// ****************************************
// Control and status fields
// ****************************************
`define CS_ENABLE 0
`define CS_START 1
`define CS_AUTO 2
`define CS_DONE 3
`define CS_IRQ_EN 4
`define CS_PRESC_LSB 5
`define CS_PRESC_MSB 7

// ****************************************
// Input select fields
// ****************************************
`define IS_CHAN_LSB 0
`define IS_CHAN_MSB 4
`define IS_LEFT_ADJ 5
`define IS_REF_LSB 6
`define IS_REF_MSB 7

// ****************************************
// Special function fields
// ****************************************
`define SF_TRIG_LSB 0
`define SF_TRIG_MSB 2

// ****************************************
// Reset values
// ****************************************
`define RST_CONTROL 8'h00
`define RST_INPUT_SELECT 8'h00
`define RST_TRIG_SEL 3'h0

// ****************************************
// Encodings
// ****************************************
`define REF_EXT_PIN 2'h0
`define REF_ANALOG_SUPPLY 2'h1
`define REF_INTERNAL_256 2'h3
`define REF_OFF 2'h2
`define CHAN_BANDGAP 5'h1e
`define CHAN_GROUND 5'h1f
`define GAIN_1X 2'h0
`define GAIN_10X 2'h1
`define GAIN_200X 2'h2
`define TRIG_OWN_DONE 3'h0

// ****************************************
// Converter clock counts
// ****************************************
`define NORMAL_CONV_CYCLES 5'd13
`define FIRST_CONV_CYCLES 5'd25
`define NORMAL_SAMPLE_AT 5'd1
`define FIRST_SAMPLE_AT 5'd13

`endif

// ===== sar_adc_sync2.v
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module sar_adc_sync2 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Level in and out
  input wire asyncIn,
  output wire syncOut
);
  reg meta_ff;
  reg stable_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      stable_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      stable_ff <= meta_ff;
    end
  end

  assign syncOut = stable_ff;
endmodule

// ===== sar_adc_prescaler.v
// Converter clock prescaler giving one tick per converter clock period
`timescale 1ns/1ps
module sar_adc_prescaler (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire run,
  input wire restart,
  input wire [2:0] ratioSel,
  // Converter clock tick
  output wire tick
);
  reg [7:0] count_ff;
  wire [7:0] lastCount;

  // Divide by 2, 4, ... 256
  assign lastCount = (8'h02 << ratioSel) - 8'h01;
  assign tick = run && !restart && (count_ff == lastCount);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 8'h00;
    end else if (!run || restart || tick) begin
      count_ff <= 8'h00;
    end else begin
      count_ff <= count_ff + 8'h01;
    end
  end
endmodule

// ===== sar_adc_conversion_control.v
// Successive-approximation converter control with APB register access
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sar_adc_ctrl_regs.vh"
module sar_adc_conversion_control (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Trigger sources, same clock, bit 0 unused
  input wire [7:0] trigIn,
  // Interrupt service
  input wire irqAck,
  output reg doneIrq,
  // Analog core
  input wire cmpIn,
  output reg analogOn,
  output reg [1:0] refSel,
  output reg [4:0] chanSel,
  output reg [1:0] gainSel,
  output reg gainBypass,
  output reg sampleHold,
  output reg [9:0] dacCode
);

  // ****************************************
  // Functions
  // ****************************************
  function isSingleEnded;
    input [4:0] code;
    begin
      isSingleEnded = (code[4:3] == 2'b00) || (code == `CHAN_BANDGAP) ||
        (code == `CHAN_GROUND);
    end
  endfunction

  function [1:0] gainOf;
    input [4:0] code;
    begin
      case (code)
        5'h08, 5'h09: gainOf = `GAIN_10X;
        5'h0a, 5'h0b: gainOf = `GAIN_200X;
        default: gainOf = `GAIN_1X;
      endcase
    end
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  reg rstMeta_ff;
  reg rstSync_ff;
  wire rst_n;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  assign rst_n = rstSync_ff;

  // ****************************************
  // Declarations
  // ****************************************
  reg enable_ff;
  reg auto_ff;
  reg done_ff;
  reg irqEn_ff;
  reg [2:0] presc_ff;
  reg [4:0] chan_ff;
  reg leftAdj_ff;
  reg [1:0] ref_ff;
  reg [2:0] trigSel_ff;
  reg [9:0] result_ff;
  reg lock_ff;
  reg pend_ff;
  reg conv_ff;
  reg first_ff;
  reg [4:0] convCnt_ff;
  reg [9:0] sar_ff;
  reg trigPrev_ff;
  reg [4:0] lockChan_ff;
  reg [1:0] lockRef_ff;
  wire cmpSync;
  wire tick;
  wire wrDone;
  wire rdDone;
  wire wrCtrl;
  wire wrStart;
  wire trigLevel;
  wire trigEdge;
  wire freeRun;
  wire [4:0] sampleAt;
  wire [4:0] lastCnt;
  wire lastTick;
  wire [4:0] trialIdx;
  wire [7:0] resHigh;
  wire [7:0] resLow;
  wire mapped;
  reg [31:0] nxt_prdata;
  localparam [7:0] RST_CTL = `RST_CONTROL;
  localparam [7:0] RST_SEL = `RST_INPUT_SELECT;

  // ****************************************
  // Submodules
  // ****************************************
  // Comparator comes from the analog side, so it is asynchronous
  sar_adc_sync2 cmpSyncInst (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(cmpIn),
    .syncOut(cmpSync)
  );

  sar_adc_prescaler prescInst (
    .clk(clk),
    .rst_n(rst_n),
    .run(enable_ff),
    .restart(trigEdge),
    .ratioSel(presc_ff),
    .tick(tick)
  );

  // ****************************************
  // APB decode
  // ****************************************
  // One wait state so that every bus output comes from a flip-flop
  assign wrDone = psel && penable && pready && pwrite;
  assign rdDone = psel && penable && pready && !pwrite;
  assign wrCtrl = wrDone && (paddr == `OFS_CONTROL_STATUS);
  assign mapped = (paddr == `OFS_CONTROL_STATUS) || (paddr == `OFS_INPUT_SELECT) ||
    (paddr == `OFS_SPECIAL_FUNC) || (paddr == `OFS_RESULT_LOW) ||
    (paddr == `OFS_RESULT_HIGH);

  // ****************************************
  // Result formatting
  // ****************************************
  assign resHigh = leftAdj_ff ? result_ff[9:2] : {6'h00, result_ff[9:8]};
  assign resLow = leftAdj_ff ? {result_ff[1:0], 6'h00} : result_ff[7:0];

  always @* begin
    nxt_prdata = 32'h00000000;
    case (paddr)
      `OFS_CONTROL_STATUS: begin
        nxt_prdata[`CS_ENABLE] = enable_ff;
        nxt_prdata[`CS_START] = pend_ff || conv_ff;
        nxt_prdata[`CS_AUTO] = auto_ff;
        nxt_prdata[`CS_DONE] = done_ff;
        nxt_prdata[`CS_IRQ_EN] = irqEn_ff;
        nxt_prdata[`CS_PRESC_MSB:`CS_PRESC_LSB] = presc_ff;
      end
      `OFS_INPUT_SELECT: begin
        nxt_prdata[`IS_CHAN_MSB:`IS_CHAN_LSB] = chan_ff;
        nxt_prdata[`IS_LEFT_ADJ] = leftAdj_ff;
        nxt_prdata[`IS_REF_MSB:`IS_REF_LSB] = ref_ff;
      end
      `OFS_SPECIAL_FUNC: nxt_prdata[`SF_TRIG_MSB:`SF_TRIG_LSB] = trigSel_ff;
      `OFS_RESULT_LOW: nxt_prdata[7:0] = resLow;
      `OFS_RESULT_HIGH: nxt_prdata[7:0] = resHigh;
      default: nxt_prdata = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : nxt_prdata;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= RST_CTL[`CS_ENABLE];
      auto_ff <= 1'b0;
      irqEn_ff <= 1'b0;
      presc_ff <= 3'h0;
      chan_ff <= RST_SEL[`IS_CHAN_MSB:`IS_CHAN_LSB];
      leftAdj_ff <= 1'b0;
      ref_ff <= 2'h0;
      trigSel_ff <= `RST_TRIG_SEL;
    end else if (wrDone) begin
      case (paddr)
        `OFS_CONTROL_STATUS: begin
          enable_ff <= pwdata[`CS_ENABLE];
          auto_ff <= pwdata[`CS_AUTO];
          irqEn_ff <= pwdata[`CS_IRQ_EN];
          presc_ff <= pwdata[`CS_PRESC_MSB:`CS_PRESC_LSB];
        end
        `OFS_INPUT_SELECT: begin
          chan_ff <= pwdata[`IS_CHAN_MSB:`IS_CHAN_LSB];
          leftAdj_ff <= pwdata[`IS_LEFT_ADJ];
          ref_ff <= pwdata[`IS_REF_MSB:`IS_REF_LSB];
        end
        `OFS_SPECIAL_FUNC: trigSel_ff <= pwdata[`SF_TRIG_MSB:`SF_TRIG_LSB];
        default: trigSel_ff <= trigSel_ff;
      endcase
    end
  end

  // ****************************************
  // Start and trigger
  // ****************************************
  // Start is ignored while disabled; software must enable first
  assign wrStart = wrCtrl && pwdata[`CS_START] && pwdata[`CS_ENABLE];
  assign trigLevel = (trigSel_ff == `TRIG_OWN_DONE) ? done_ff : trigIn[trigSel_ff];
  // Only an idle converter sees an edge; a held level never retriggers
  assign trigEdge = enable_ff && auto_ff && trigLevel && !trigPrev_ff &&
    !pend_ff && !conv_ff;
  assign freeRun = auto_ff && (trigSel_ff == `TRIG_OWN_DONE);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev_ff <= 1'b0;
    end else begin
      trigPrev_ff <= trigLevel;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  assign sampleAt = first_ff ? `FIRST_SAMPLE_AT : `NORMAL_SAMPLE_AT;
  assign lastCnt = (first_ff ? `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES) - 5'd1;
  assign lastTick = conv_ff && tick && (convCnt_ff == lastCnt);
  assign trialIdx = convCnt_ff - sampleAt - 5'd1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
      conv_ff <= 1'b0;
      first_ff <= 1'b1;
      convCnt_ff <= 5'd0;
      sar_ff <= 10'h000;
    end else if (!enable_ff) begin
      // Disabling aborts any conversion and re-arms the long first one
      pend_ff <= 1'b0;
      conv_ff <= 1'b0;
      first_ff <= 1'b1;
      convCnt_ff <= 5'd0;
      sar_ff <= 10'h000;
    end else begin
      if ((wrStart || trigEdge) && !conv_ff) begin
        pend_ff <= 1'b1;
      end else if (pend_ff && tick) begin
        pend_ff <= 1'b0;
      end
      if (pend_ff && tick && !conv_ff) begin
        conv_ff <= 1'b1;
        convCnt_ff <= 5'd0;
        sar_ff <= 10'h000;
      end else if (lastTick) begin
        // Clear trials so a free-running restart begins from zero
        sar_ff <= 10'h000;
        first_ff <= 1'b0;
        convCnt_ff <= 5'd0;
        conv_ff <= freeRun;
      end else if (conv_ff && tick) begin
        convCnt_ff <= convCnt_ff + 5'd1;
        if (convCnt_ff > sampleAt + 5'd1) begin
          // Comparator lags three clocks; needs four clocks per tick at least
          sar_ff[4'd10 - trialIdx[3:0]] <= cmpSync;
          sar_ff[4'd9 - trialIdx[3:0]] <= 1'b1;
        end else if (convCnt_ff == sampleAt) begin
          sar_ff[9] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Result, lock and done flag
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= 10'h000;
      lock_ff <= 1'b0;
    end else begin
      if (lastTick && !lock_ff) begin
        result_ff <= {sar_ff[9:1], cmpSync};
      end
      if (rdDone && (paddr == `OFS_RESULT_HIGH)) begin
        lock_ff <= 1'b0;
      end else if (rdDone && (paddr == `OFS_RESULT_LOW)) begin
        lock_ff <= 1'b1;
      end
    end
  end

  // Set beats clear when both land in one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else if (lastTick) begin
      done_ff <= 1'b1;
    end else if (irqAck || (wrCtrl && pwdata[`CS_DONE])) begin
      done_ff <= 1'b0;
    end
  end

  // ****************************************
  // Analog core drive
  // ****************************************
  // Selections are held through a conversion, reopened in its last clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockChan_ff <= 5'h00;
      lockRef_ff <= `REF_EXT_PIN;
    end else if (!conv_ff || (tick && convCnt_ff == lastCnt)) begin
      lockChan_ff <= chan_ff;
      lockRef_ff <= ref_ff;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analogOn <= 1'b0;
      refSel <= `REF_EXT_PIN;
      chanSel <= 5'h00;
      gainSel <= `GAIN_1X;
      gainBypass <= 1'b1;
      sampleHold <= 1'b0;
      dacCode <= 10'h000;
      doneIrq <= 1'b0;
    end else begin
      analogOn <= enable_ff;
      refSel <= enable_ff ? lockRef_ff : `REF_EXT_PIN;
      chanSel <= enable_ff ? lockChan_ff : `CHAN_GROUND;
      gainSel <= enable_ff ? gainOf(lockChan_ff) : `GAIN_1X;
      gainBypass <= enable_ff ? isSingleEnded(lockChan_ff) : 1'b1;
      sampleHold <= conv_ff && (convCnt_ff >= sampleAt);
      dacCode <= sar_ff;
      doneIrq <= done_ff && irqEn_ff;
    end
  end

endmodule

// ===== sar_adc_ctrl_properties.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module sar_adc_ctrl_checker (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bus handshake
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Interrupt
  input wire irqAck,
  input wire doneIrq,
  // Analog core
  input wire analogOn,
  input wire [1:0] refSel,
  input wire [4:0] chanSel,
  input wire [1:0] gainSel,
  input wire gainBypass,
  input wire sampleHold,
  input wire [9:0] dacCode
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_apb_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_ref_legal: assert property (refSel != 2'h2)
    else $error("unused reference code driven");
  a_single_bypass: assert property ((chanSel[4:3] == 2'h0 || chanSel >= 5'h1e) |-> gainBypass)
    else $error("single-ended channel not bypassed");
  a_gain_high: assert property (!gainBypass && chanSel[4:1] == 4'h5 |-> gainSel == 2'h2)
    else $error("wrong gain for high-gain pair");
  a_off_quiet: assert property (!analogOn && !$past(analogOn) |-> !sampleHold && refSel == 2'h0)
    else $error("converter active while off");
  // Hold spans twelve ticks; eight cycles is well under the 48 that the bench sees
  a_hold_span: assert property ($rose(sampleHold) |-> (sampleHold || !analogOn) [*8])
    else $error("sample hold too short");
  a_first_trial: assert property ($rose(sampleHold) |-> ##[0:8] dacCode == 10'h200)
    else $error("first trial code not midscale");
  a_ack_clears: assert property (irqAck && !sampleHold && !$past(sampleHold) && !$past(sampleHold, 2) |-> ##2 !doneIrq)
    else $error("interrupt service did not clear done");
  c_conv: cover property ($rose(sampleHold));
  c_err: cover property (pslverr);
  c_ack: cover property (irqAck && doneIrq);
endmodule
bind sar_adc_conversion_control sar_adc_ctrl_checker chk (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .irqAck(irqAck), .doneIrq(doneIrq), .analogOn(analogOn), .refSel(refSel),
  .chanSel(chanSel), .gainSel(gainSel), .gainBypass(gainBypass),
  .sampleHold(sampleHold), .dacCode(dacCode));

// ===== sar_analog_model.sv
// Behavioural analog core: comparator against a test level
`timescale 1ns/1ps
module sar_analog_model (
  // Clock
  input wire clk,
  // From the control block
  input wire analogOn,
  input wire [9:0] dacCode,
  // Input level as a code
  input wire [9:0] level,
  // Comparator answer
  output wire cmpIn
);
  // ****
  // Comparator
  // ****
  logic noise = 1'h0;
  // Powered-down comparator gives no steady answer
  always @(posedge clk) begin
    noise <= ~noise;
  end
  assign cmpIn = analogOn ? (level >= dacCode) : noise;
endmodule

// ===== sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sar_adc_ctrl_regs.vh"
module sar_adc_conversion_control_tb;
  // ****
  // Stimulus, design and core model
  // ****
  logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, irqAck = 1'h0;
  logic [7:0] paddr = 8'h0, trigIn = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [9:0] level = 10'h0, r;
  logic [64:0] e;
  logic [64:0] expq[$];
  wire pready, pslverr, doneIrq, cmpIn, analogOn, gainBypass, sampleHold;
  wire [31:0] prdata;
  wire [1:0] refSel, gainSel;
  wire [4:0] chanSel;
  wire [9:0] dacCode;
  integer seed = 32'hd67c, error_cnt = 0, checks = 0, i;
  always #5 clk = ~clk;
  sar_adc_conversion_control uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigIn(trigIn), .irqAck(irqAck), .doneIrq(doneIrq), .cmpIn(cmpIn),
    .analogOn(analogOn), .refSel(refSel), .chanSel(chanSel), .gainSel(gainSel),
    .gainBypass(gainBypass), .sampleHold(sampleHold), .dacCode(dacCode));
  sar_analog_model core (.clk(clk), .analogOn(analogOn), .dacCode(dacCode), .level(level),
    .cmpIn(cmpIn));
  // ****
  // Tasks
  // ****
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Note holds expected error flag, data mask and masked data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic err);
    integer n;
    expq.push_back({err, m, d & m});
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 32'h0, 1'h0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'h0, a, x, m, 1'h0);
  endtask
  task automatic wait_done();
    integer n;
    n = 0;
    do begin
      apb(1'h0, `OFS_CONTROL_STATUS, 32'h0, 32'h0, 1'h0);
      n++;
    end while (rd[`CS_DONE] !== 1'h1 && n < 200);
    if (n >= 200) error_cnt++;
  endtask
  task automatic res(input logic [9:0] v, input logic left);
    rdx(`OFS_RESULT_LOW, left ? {24'h0, v[1:0], 6'h0} : {24'h0, v[7:0]}, 32'hffffffff);
    rdx(`OFS_RESULT_HIGH, left ? {24'h0, v[9:2]} : {30'h0, v[9:8]}, 32'hffffffff);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****
  // Result monitor and watchdog
  // ****
  always @(posedge clk) begin
    if (pready === 1'h1) begin
      e = expq.pop_front();
      if (e[63:32] != 32'h0) cmp("prdata", e[31:0], prdata & e[63:32]);
      cmp("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
    end
  end
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    rdx(`OFS_CONTROL_STATUS, {24'h0, `RST_CONTROL}, 32'hffffffff);
    rdx(`OFS_INPUT_SELECT, {24'h0, `RST_INPUT_SELECT}, 32'hffffffff);
    apb(1'h0, 8'h14, 32'h0, 32'hffffffff, 1'h1);
    wr(`OFS_CONTROL_STATUS, 32'h31);
    // Reference codes 0, 1 and 3, both alignments
    for (i = 0; i < 3; i++) begin
      level <= 10'($random(seed));
      wr(`OFS_INPUT_SELECT, {24'h0, (i == 2) ? 2'h3 : 2'(i), i[0], 5'(i + 3)});
      repeat (4) @(posedge clk);
      cmp("refSel", (i == 2) ? 32'h3 : 32'(i), {30'h0, refSel});
      cmp("chanSel", 32'(i + 3), {27'h0, chanSel});
      cmp("gainBypass", 32'h1, {31'h0, gainBypass});
      wr(`OFS_CONTROL_STATUS, 32'h33);
      rdx(`OFS_CONTROL_STATUS, 32'h2, 32'h2);
      wait_done();
      rdx(`OFS_CONTROL_STATUS, 32'h8, 32'ha);
      res(level, i[0]);
      wr(`OFS_CONTROL_STATUS, 32'h39);
    end
    // Lock after low read; channel change deferred to completion
    r = level;
    rdx(`OFS_RESULT_LOW, {24'h0, r[7:0]}, 32'hff);
    level <= ~r;
    wr(`OFS_CONTROL_STATUS, 32'h33);
    wr(`OFS_INPUT_SELECT, 32'h7);
    cmp("chanSel", 32'h5, {27'h0, chanSel});
    wait_done();
    repeat (4) @(posedge clk);
    cmp("chanSel", 32'h7, {27'h0, chanSel});
    res(r, 1'h0);
    // Free running without clearing done
    wr(`OFS_SPECIAL_FUNC, {29'h0, `TRIG_OWN_DONE});
    wr(`OFS_CONTROL_STATUS, 32'h37);
    repeat (90) @(posedge clk);
    level <= 10'($random(seed));
    repeat (120) @(posedge clk);
    rdx(`OFS_CONTROL_STATUS, 32'ha, 32'ha);
    res(level, 1'h0);
    wr(`OFS_CONTROL_STATUS, 32'h39);
    repeat (60) @(posedge clk);
    // External trigger edge, then a level held high
    wr(`OFS_SPECIAL_FUNC, 32'h3);
    wr(`OFS_CONTROL_STATUS, 32'h3d);
    level <= 10'($random(seed));
    trigIn <= 8'h08;
    wait_done();
    res(level, 1'h0);
    wr(`OFS_CONTROL_STATUS, 32'h3d);
    repeat (80) @(posedge clk);
    rdx(`OFS_CONTROL_STATUS, 32'h0, 32'ha);
    // Start bit with auto-trigger on, then interrupt service
    trigIn <= 8'h00;
    level <= 10'($random(seed));
    wr(`OFS_CONTROL_STATUS, 32'h37);
    wait_done();
    res(level, 1'h0);
    cmp("doneIrq", 32'h1, {31'h0, doneIrq});
    irqAck <= 1'h1;
    @(posedge clk);
    irqAck <= 1'h0;
    repeat (3) @(posedge clk);
    cmp("doneIrq", 32'h0, {31'h0, doneIrq});
    // High-gain differential pair, then disable powers the core down
    wr(`OFS_INPUT_SELECT, 32'h0a);
    repeat (4) @(posedge clk);
    cmp("gainSel", 32'h2, {30'h0, gainSel});
    cmp("gainBypass", 32'h0, {31'h0, gainBypass});
    wr(`OFS_CONTROL_STATUS, 32'h0);
    repeat (4) @(posedge clk);
    cmp("gainBypass", 32'h1, {31'h0, gainBypass});
    cmp("analogOn", 32'h0, {31'h0, analogOn});
    cmp("chanSel", 32'h1f, {27'h0, chanSel});
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
